// File: logic/pci_map.svh
// register offsets, reset values and field positions of the pin change interrupt block
`ifndef PCI_MAP_SVH
`define PCI_MAP_SVH
`define PCI_ADDR_W 3
`define PCI_OFF_RISE 3'h0
`define PCI_OFF_FALL 3'h1
`define PCI_OFF_FLAG 3'h2
`define PCI_OFF_CTRL 3'h3
`define PCI_OFF_IRQ_STAT 3'h4
`define PCI_OFF_IRQ_CLR 3'h5
`define PCI_OFF_IRQ_EN 3'h6
`define PCI_RST_RISE 8'h00
`define PCI_RST_FALL 8'h00
`define PCI_RST_FLAG 8'h00
`define PCI_RST_CTRL 2'h0
`define PCI_RST_IRQ 2'h0
`define PCI_CTRL_MASTER_EN 0
`define PCI_CTRL_SLEEP 1
`define PCI_CTRL_SUMMARY 2
`define PCI_IRQ_EDGE 0
`define PCI_IRQ_WAKE 1
`endif

// File: logic/pci_pkg.sv
// types shared by the pin change interrupt block
package pci_pkg;
  typedef logic [7:0] pci_byte_t;
  typedef logic [2:0] pci_addr_t;
  typedef enum logic [1:0] {
    PCI_RUN = 2'b00,
    PCI_SLEEP = 2'b01,
    PCI_WAKE = 2'b10
  } pci_power_e;
endpackage

// File: logic/pci_sync.sv
// two flip-flop synchroniser for the eight watched pins
module pci_sync (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // pins in, synchronised pins out
  input wire pci_pkg::pci_byte_t watched_pin,
  output pci_pkg::pci_byte_t pin_sync
);
  pci_pkg::pci_byte_t stage1_reg;
  pci_pkg::pci_byte_t stage2_reg;

  // first stage feeds only the second
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stage1_reg <= 8'h00;
      stage2_reg <= 8'h00;
    end else begin
      stage1_reg <= watched_pin;
      stage2_reg <= stage1_reg;
    end
  end

  assign pin_sync = stage2_reg;
endmodule

// File: logic/pci_edge.sv
// per-pin rising and falling edge detector against the previous sample
module pci_edge (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // synchronised pins and per-pin enables
  input wire pci_pkg::pci_byte_t pin_sync,
  input wire pci_pkg::pci_byte_t rise_en,
  input wire pci_pkg::pci_byte_t fall_en,
  // one-cycle pulse per enabled edge
  output pci_pkg::pci_byte_t edge_hit
);
  pci_pkg::pci_byte_t prev_reg;
  logic [1:0] warm_reg;
  logic primed;
  pci_pkg::pci_byte_t rise_w;
  pci_pkg::pci_byte_t fall_w;

  // wait three edges so synchroniser and previous sample hold real levels;
  // a pin idling high would otherwise look like a rise after reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prev_reg <= 8'h00;
      warm_reg <= 2'h0;
    end else begin
      prev_reg <= pin_sync;
      if (!primed) warm_reg <= warm_reg + 2'h1;
    end
  end
  assign primed = (warm_reg == 2'h3);

  // once primed, each transition is seen in exactly one cycle
  assign rise_w = pin_sync & ~prev_reg & {8{primed}};
  assign fall_w = ~pin_sync & prev_reg & {8{primed}};
  // independent per-pin gating, both enables give both edges
  assign edge_hit = (rise_w & rise_en) | (fall_w & fall_en);
endmodule

// File: logic/pci_top.sv
// pin change interrupt block: registers, flags, wake and interrupt outputs
//
// Design decisions made here: the register addresses and the strobed register port.
`include "pci_map.svh"
module pci_top (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // watched port pins
  input wire pci_pkg::pci_byte_t watched_pin,
  // register port
  input wire pci_pkg::pci_addr_t reg_addr,
  input wire pci_pkg::pci_byte_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output pci_pkg::pci_byte_t reg_rdata,
  // to the cpu interrupt controller and power control
  output logic change_int_summary_flag,
  output logic change_int_req,
  output logic wake_req,
  output logic irq
);
  pci_pkg::pci_byte_t rise_reg;
  pci_pkg::pci_byte_t fall_reg;
  pci_pkg::pci_byte_t flag_reg;
  pci_pkg::pci_byte_t flag_next;
  pci_pkg::pci_byte_t rdata_reg;
  pci_pkg::pci_byte_t rdata_next;
  pci_pkg::pci_byte_t pin_sync;
  pci_pkg::pci_byte_t edge_hit;
  logic master_en_reg;
  logic sleep_reg;
  logic [1:0] irq_stat_reg;
  logic [1:0] irq_stat_next;
  logic [1:0] irq_en_reg;
  logic [1:0] irq_ev;
  pci_pkg::pci_power_e power_reg;
  pci_pkg::pci_power_e power_next;

  // address decode
  wire wr_rise = reg_wr && (reg_addr == `PCI_OFF_RISE);
  wire wr_fall = reg_wr && (reg_addr == `PCI_OFF_FALL);
  wire wr_flag = reg_wr && (reg_addr == `PCI_OFF_FLAG);
  wire wr_ctrl = reg_wr && (reg_addr == `PCI_OFF_CTRL);
  wire wr_iclr = reg_wr && (reg_addr == `PCI_OFF_IRQ_CLR);
  wire wr_ien = reg_wr && (reg_addr == `PCI_OFF_IRQ_EN);
  wire any_edge = |edge_hit;

  pci_sync u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .watched_pin(watched_pin),
    .pin_sync(pin_sync)
  );

  pci_edge u_edge (
    .clk(clk),
    .rst_b(rst_b),
    .pin_sync(pin_sync),
    .rise_en(rise_reg),
    .fall_en(fall_reg),
    .edge_hit(edge_hit)
  );

  // flags: software writes the byte, hardware set wins
  assign flag_next = (wr_flag ? reg_wdata : flag_reg) | edge_hit;

  // summary and interrupt request; master gates the request, not the summary
  assign change_int_summary_flag = |flag_reg;
  assign change_int_req = master_en_reg && change_int_summary_flag;

  // sleep state machine: wake only through the master enable
  always_comb begin
    power_next = power_reg;
    unique case (power_reg)
      pci_pkg::PCI_RUN: begin
        if (wr_ctrl && reg_wdata[`PCI_CTRL_SLEEP]) begin
          power_next = pci_pkg::PCI_SLEEP;
        end
      end
      pci_pkg::PCI_SLEEP: begin
        if (master_en_reg && any_edge) begin
          power_next = pci_pkg::PCI_WAKE;
        end
      end
      pci_pkg::PCI_WAKE: begin
        power_next = pci_pkg::PCI_RUN;
      end
      default: begin
        power_next = pci_pkg::PCI_RUN;
      end
    endcase
  end
  // wake pulse rises on the same edge as the flag update, so the flag is visible with it
  assign wake_req = (power_reg == pci_pkg::PCI_WAKE);

  // event status: set wins over the clear
  assign irq_ev[`PCI_IRQ_EDGE] = any_edge;
  assign irq_ev[`PCI_IRQ_WAKE] = wake_req;
  assign irq_stat_next = (irq_stat_reg & ~(wr_iclr ? reg_wdata[1:0] : 2'h0)) | irq_ev;
  assign irq = |(irq_stat_reg & irq_en_reg);

  // read mux, unmapped addresses read zero
  always_comb begin
    rdata_next = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        `PCI_OFF_RISE: rdata_next = rise_reg;
        `PCI_OFF_FALL: rdata_next = fall_reg;
        `PCI_OFF_FLAG: rdata_next = flag_reg;
        `PCI_OFF_CTRL: rdata_next = {5'h00, change_int_summary_flag, sleep_reg, master_en_reg};
        `PCI_OFF_IRQ_STAT: rdata_next = {6'h00, irq_stat_reg};
        `PCI_OFF_IRQ_EN: rdata_next = {6'h00, irq_en_reg};
        default: rdata_next = 8'h00;
      endcase
    end
  end
  assign reg_rdata = rdata_reg;

  // configuration registers; enables and flags clear on reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rise_reg <= `PCI_RST_RISE;
      fall_reg <= `PCI_RST_FALL;
      flag_reg <= `PCI_RST_FLAG;
    end else begin
      if (wr_rise) rise_reg <= reg_wdata;
      if (wr_fall) fall_reg <= reg_wdata;
      flag_reg <= flag_next;
    end
  end

  // control, power and interrupt registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      master_en_reg <= 1'b0;
      power_reg <= pci_pkg::PCI_RUN;
      irq_stat_reg <= `PCI_RST_IRQ;
      irq_en_reg <= `PCI_RST_IRQ;
      rdata_reg <= 8'h00;
    end else begin
      if (wr_ctrl) master_en_reg <= reg_wdata[`PCI_CTRL_MASTER_EN];
      power_reg <= power_next;
      irq_stat_reg <= irq_stat_next;
      if (wr_ien) irq_en_reg <= reg_wdata[1:0];
      rdata_reg <= rdata_next;
    end
  end
  assign sleep_reg = (power_reg == pci_pkg::PCI_SLEEP);

  // assertions
  property p_rise_sets;
    @(posedge clk) disable iff (!rst_b)
    (pin_sync[0] && !$past(pin_sync[0]) && rise_reg[0] && $past(rst_b, 3)) |=> flag_reg[0];
  endproperty
  a_rise_sets: assert property (p_rise_sets) else $error("enabled rising edge did not set flag");

  property p_fall_sets;
    @(posedge clk) disable iff (!rst_b)
    (!pin_sync[0] && $past(pin_sync[0]) && fall_reg[0] && $past(rst_b, 3)) |=> flag_reg[0];
  endproperty
  a_fall_sets: assert property (p_fall_sets) else $error("enabled falling edge did not set flag");

  property p_no_edge_disabled;
    @(posedge clk) disable iff (!rst_b)
    (!rise_reg[1] && !fall_reg[1]) |-> !edge_hit[1];
  endproperty
  a_no_edge_disabled: assert property (p_no_edge_disabled) else $error("edge seen on disabled pin");

  property p_pin_to_flag;
    @(posedge clk) disable iff (!rst_b)
    ($rose(watched_pin[2]) && $past(rst_b) && rise_reg[2] && !wr_flag) ##1 (rise_reg[2] && !wr_flag) ##1
    (rise_reg[2] && !wr_flag) |-> ##[1:2] flag_reg[2];
  endproperty
  a_pin_to_flag: assert property (p_pin_to_flag) else $error("pin rise not flagged in time");

  property p_set_wins;
    @(posedge clk) disable iff (!rst_b)
    (wr_flag && reg_wdata[3] == 1'b0 && edge_hit[3]) |=> flag_reg[3];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat a coincident edge");

  property p_clear;
    @(posedge clk) disable iff (!rst_b)
    (wr_flag && reg_wdata == 8'h00 && edge_hit == 8'h00) |=> flag_reg == 8'h00;
  endproperty
  a_clear: assert property (p_clear) else $error("zero write did not clear flags");

  property p_summary;
    @(posedge clk) disable iff (!rst_b)
    change_int_summary_flag == (flag_reg != 8'h00);
  endproperty
  a_summary: assert property (p_summary) else $error("summary flag disagrees with pin flags");

  property p_req_gated;
    @(posedge clk) disable iff (!rst_b)
    (any_edge && !master_en_reg && !wr_ctrl) |=> (change_int_summary_flag && !change_int_req);
  endproperty
  a_req_gated: assert property (p_req_gated) else $error("request raised with master off");

  property p_req_on;
    @(posedge clk) disable iff (!rst_b)
    (any_edge && master_en_reg && !wr_ctrl) |=> change_int_req;
  endproperty
  a_req_on: assert property (p_req_on) else $error("no request for enabled edge");

  property p_wake;
    @(posedge clk) disable iff (!rst_b)
    (sleep_reg && master_en_reg && any_edge) |=> (wake_req && flag_reg != 8'h00) ##1 !sleep_reg;
  endproperty
  a_wake: assert property (p_wake) else $error("sleep edge did not wake with flag set");

  property p_no_wake;
    @(posedge clk) disable iff (!rst_b)
    (sleep_reg && !master_en_reg && !wr_ctrl) |=> !wake_req;
  endproperty
  a_no_wake: assert property (p_no_wake) else $error("woke with master disabled");

  property p_rise_off;
    @(posedge clk) disable iff (!rst_b)
    (pin_sync[4] && !$past(pin_sync[4]) && !rise_reg[4]) |-> !edge_hit[4];
  endproperty
  a_rise_off: assert property (p_rise_off) else $error("rising edge seen with rise enable off");

  property p_fall_off;
    @(posedge clk) disable iff (!rst_b)
    (!pin_sync[4] && $past(pin_sync[4]) && !fall_reg[4]) |-> !edge_hit[4];
  endproperty
  a_fall_off: assert property (p_fall_off) else $error("falling edge seen with fall enable off");

  property p_both;
    @(posedge clk) disable iff (!rst_b)
    (rise_reg[2] && fall_reg[2] && $changed(pin_sync[2]) && $past(rst_b, 3)) |-> edge_hit[2];
  endproperty
  a_both: assert property (p_both) else $error("both enables missed a change");

  property p_stable_no_edge;
    @(posedge clk) disable iff (!rst_b)
    $stable(pin_sync) |-> (edge_hit == 8'h00);
  endproperty
  a_stable_no_edge: assert property (p_stable_no_edge) else $error("edge seen on a steady pin");

  property p_flag_sticky;
    @(posedge clk) disable iff (!rst_b)
    (flag_reg[2] && !wr_flag) |=> flag_reg[2];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped without a write");

  property p_no_spurious;
    @(posedge clk) disable iff (!rst_b)
    (!flag_reg[7] && !wr_flag && !edge_hit[7]) |=> !flag_reg[7];
  endproperty
  a_no_spurious: assert property (p_no_spurious) else $error("flag set with no enabled edge");

  property p_reset_vals;
    @(posedge clk) disable iff (!rst_b)
    !$past(rst_b) |-> (flag_reg == 8'h00 && fall_reg == 8'h00);
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("flags or fall enables not zero after reset");

  property p_req_off;
    @(posedge clk) disable iff (!rst_b)
    !master_en_reg |-> !change_int_req;
  endproperty
  a_req_off: assert property (p_req_off) else $error("request with master off");

  property p_stat_edge;
    @(posedge clk) disable iff (!rst_b)
    any_edge |=> irq_stat_reg[`PCI_IRQ_EDGE];
  endproperty
  a_stat_edge: assert property (p_stat_edge) else $error("edge event not recorded in status");

  property p_sleep_entry;
    @(posedge clk) disable iff (!rst_b)
    (power_reg == pci_pkg::PCI_RUN && wr_ctrl && reg_wdata[`PCI_CTRL_SLEEP]) |=> sleep_reg;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("sleep write did not enter sleep");

  property p_wake_pulse;
    @(posedge clk) disable iff (!rst_b)
    wake_req |=> (!wake_req && !sleep_reg);
  endproperty
  a_wake_pulse: assert property (p_wake_pulse) else $error("wake pulse longer than one cycle");

  property p_wake_records;
    @(posedge clk) disable iff (!rst_b)
    wake_req |-> (flag_reg != 8'h00);
  endproperty
  a_wake_records: assert property (p_wake_records) else $error("woke before the flag was recorded");

  c_edge: cover property (@(posedge clk) disable iff (!rst_b) any_edge && master_en_reg);
  c_wake: cover property (@(posedge clk) disable iff (!rst_b) wake_req);
  c_race: cover property (@(posedge clk) disable iff (!rst_b) wr_flag && any_edge);
  c_irq: cover property (@(posedge clk) disable iff (!rst_b) irq);
  c_sleep_masked: cover property (@(posedge clk) disable iff (!rst_b) sleep_reg && !master_en_reg && any_edge);
endmodule

// File: testbench/pci_pin_model.sv
// stand-in for the external signals on the watched port pins
module pci_pin_model (
  // pins toward the block
  output pci_pkg::pci_byte_t watched_pin,
  // clock that paces each level change
  input wire logic clk
);
  timeunit 1ns;
  timeprecision 1ps;

  // pins start low and stable so reset sees no change
  initial watched_pin = 8'h00;

  // new level just after an edge, then held so the synchroniser sees it cleanly
  task automatic drive(input pci_pkg::pci_byte_t lvl, input int hold);
    @(posedge clk);
    watched_pin <= lvl;
    repeat (hold) @(posedge clk);
  endtask
endmodule

// File: testbench/test_pin_change_interrupt.sv
// self-checking bench for the pin change interrupt block
`include "pci_map.svh"
module test_pin_change_interrupt;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  pci_pkg::pci_addr_t reg_addr = 3'h0;
  pci_pkg::pci_byte_t reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  pci_pkg::pci_byte_t reg_rdata;
  pci_pkg::pci_byte_t watched_pin;
  logic change_int_summary_flag;
  logic change_int_req;
  logic wake_req;
  logic irq;
  pci_pkg::pci_byte_t rd_val;
  int err_count = 0;
  int n_tests = 0;

  // 25 MHz system clock
  always #20 clk = ~clk;

  pci_top pci_top_inst (.clk(clk), .rst_b(rst_b), .watched_pin(watched_pin), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .change_int_summary_flag(change_int_summary_flag), .change_int_req(change_int_req),
    .wake_req(wake_req), .irq(irq));
  pci_pin_model pci_pin_model_inst (.watched_pin(watched_pin), .clk(clk));

  // compare, count, report at once
  task automatic chk(input string what, input pci_pkg::pci_byte_t exp, input pci_pkg::pci_byte_t got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one-cycle write strobe
  task automatic reg_write(input pci_pkg::pci_addr_t a, input pci_pkg::pci_byte_t d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1; // let the write land before anyone looks at the outputs
  endtask

  // data stands only in the cycle after the strobe, taken once it settles
  task automatic reg_read(input pci_pkg::pci_addr_t a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask

  // every readable place, unmapped one too, comes up zero
  task automatic t_reset();
    for (int i = 0; i < 8; i++) begin
      if (i != 5) begin
        reg_read(3'(i));
        chk("reset value", 8'h00, rd_val);
      end
    end
    reg_write(3'h7, 8'hff);
    reg_read(3'h7);
    chk("unmapped read", 8'h00, rd_val);
  endtask

  // pin 0 rise only, pin 2 both ways, pin 3 fall only, rest off
  task automatic t_edges();
    reg_write(`PCI_OFF_RISE, 8'h05);
    reg_write(`PCI_OFF_FALL, 8'h0c);
    pci_pin_model_inst.drive(8'hff, 4);
    reg_read(`PCI_OFF_FLAG);
    chk("rise flags", 8'h05, rd_val);
    chk("summary set", 8'h01, {7'h00, change_int_summary_flag});
    chk("req masked", 8'h00, {7'h00, change_int_req});
    reg_write(`PCI_OFF_FLAG, 8'h00);
    reg_read(`PCI_OFF_FLAG);
    chk("flags cleared", 8'h00, rd_val);
    chk("summary clear", 8'h00, {7'h00, change_int_summary_flag});
    pci_pin_model_inst.drive(8'h00, 4);
    reg_read(`PCI_OFF_FLAG);
    chk("fall flags", 8'h0c, rd_val);
    reg_write(`PCI_OFF_CTRL, 8'h01);
    chk("req raised", 8'h01, {7'h00, change_int_req});
  endtask

  // clearing write lands on the edge that sets pin 0
  task automatic t_clear_race();
    reg_read(`PCI_OFF_FLAG);
    pci_pin_model_inst.drive(8'h01, 0);
    @(posedge clk);
    reg_write(`PCI_OFF_FLAG, (rd_val ^ 8'hff) & rd_val);
    reg_read(`PCI_OFF_FLAG);
    chk("race flag kept", 8'h01, rd_val);
  endtask

  // enable, clear and mask the edge interrupt
  task automatic t_irq();
    reg_write(`PCI_OFF_IRQ_EN, 8'h01);
    chk("irq on", 8'h01, {7'h00, irq});
    reg_write(`PCI_OFF_IRQ_CLR, 8'h03);
    chk("irq cleared", 8'h00, {7'h00, irq});
    pci_pin_model_inst.drive(8'h05, 4);
    chk("irq again", 8'h01, {7'h00, irq});
    reg_write(`PCI_OFF_IRQ_EN, 8'h00);
    chk("irq masked", 8'h00, {7'h00, irq});
    reg_read(`PCI_OFF_IRQ_STAT);
    chk("irq status", 8'h01, rd_val);
    reg_write(`PCI_OFF_IRQ_CLR, 8'h03);
    reg_write(`PCI_OFF_FLAG, 8'h00);
  endtask

  // asleep with master off: flag only; then master on, a rising pin 2 wakes the core
  task automatic t_sleep();
    logic seen;
    seen = 1'b0;
    reg_write(`PCI_OFF_CTRL, 8'h02);
    pci_pin_model_inst.drive(8'h01, 0);
    repeat (10) begin
      @(posedge clk);
      #1 if (wake_req !== 1'b0) seen = 1'b1;
    end
    chk("no wake", 8'h00, {7'h00, seen});
    reg_read(`PCI_OFF_CTRL);
    chk("asleep flagged", 8'h06, rd_val);
    reg_write(`PCI_OFF_FLAG, 8'h00);
    reg_write(`PCI_OFF_CTRL, 8'h03);
    reg_read(`PCI_OFF_CTRL);
    chk("asleep", 8'h03, rd_val);
    seen = 1'b0;
    pci_pin_model_inst.drive(8'h05, 0);
    repeat (20) begin
      @(posedge clk);
      #1 if (wake_req === 1'b1) seen = 1'b1;
    end
    chk("wake pulse", 8'h01, {7'h00, seen});
    reg_read(`PCI_OFF_FLAG);
    chk("sleep flag", 8'h04, rd_val);
    reg_read(`PCI_OFF_IRQ_STAT);
    chk("wake status", 8'h03, rd_val);
    reg_read(`PCI_OFF_CTRL);
    chk("awake", 8'h05, rd_val);
  endtask

  // verdict and end of run
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // main sequence after two cycles of reset
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_edges();
    t_clear_race();
    t_irq();
    t_sleep();
    close_out();
  end

  // the whole run needs about 120 cycles; this cuts a hang short
  initial begin
    #100us;
    err_count++;
    close_out();
  end
endmodule
